// file: common/dma_channel_control_consts.vh
// Constants for the six-channel DMA control block
`ifndef DMA_CHANNEL_CONTROL_CONSTS_VH
`define DMA_CHANNEL_CONTROL_CONSTS_VH

// Sizes
`define NUM_CH 6
`define CTL_W 24
`define CNT_W 16
`define LINE_W 3

// Control register fields
`define GO_BIT 23
`define IRQ_EN_BIT 22
`define MODE_HI 21
`define MODE_LO 19
`define RANK_HI 18
`define RANK_LO 17
`define CTL_RESET 24'h000000

// Transfer mode codes
`define MODE_BLK_REQ 3'h0
`define MODE_WORD_REQ 3'h1
`define MODE_LINE_REQ 3'h2
`define MODE_BLK_GO 3'h3
`define MODE_BLK_REPEAT 3'h4
`define MODE_WORD_REPEAT 3'h5

// Words per line, minus one
`define LINE_LAST 3'h3

// APB region codes and byte addresses
`define REGION_CTL 3'h0
`define REGION_PRESET 3'h1
`define ADDR_STATUS 8'h40
`define ADDR_MASK 8'h44
`define ADDR_BUSY 8'h48

// Fields of the APB byte address
`define REGION_HI 7
`define REGION_LO 5
`define IDX_HI 4
`define IDX_LO 2

// Status, mask and busy readback layout
`define STAT_EOB_HI 5
`define STAT_EOB_LO 0
`define STAT_STOP_HI 13
`define STAT_STOP_LO 8
`define BUSY_HI 5
`define BUSY_LO 0

// Channel phases
`define PH_IDLE 2'h0
`define PH_WAIT 2'h1
`define PH_RUN 2'h2

`endif

// file: tb/dma_channel_control_checker.sv
// Port assertions for the DMA channel control block
`timescale 1ns/1ps
module dma_channel_control_checker (
  // Clock and reset
  input wire I_CLK,
  input wire I_RST_N,
  // APB
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire O_PREADY,
  input wire O_PSLVERR,
  // Transfer and interrupt
  input wire [5:0] O_WORD_MOVE,
  input wire [5:0] O_CHAN_BUSY,
  input wire O_IRQ
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  // Access still waiting for its answer
  sequence s_wait;
    I_PSEL && I_PENABLE && !O_PREADY;
  endsequence
  // Access taken at this edge
  sequence s_taken;
    I_PSEL && I_PENABLE && O_PREADY;
  endsequence
  chk_ready_one_wait: assert property (s_wait |=> O_PREADY)
    else $error("pready late");
  chk_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("pready stuck");
  chk_err_with_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("pslverr alone");
  chk_unmapped_err: assert property ((s_taken ##0 (I_PADDR == 8'h18)) |-> O_PSLVERR)
    else $error("unmapped not refused");
  chk_mapped_ok: assert property ((s_taken ##0 (I_PADDR == 8'h00)) |-> !O_PSLVERR)
    else $error("mapped refused");
  // Only an APB write two cycles earlier, to any address, may drop a pending interrupt
  chk_irq_held: assert property ($fell(O_IRQ) |-> $past(I_PSEL && I_PENABLE && I_PWRITE, 2))
    else $error("irq dropped alone");
  chk_move_onehot: assert property ($onehot0(O_WORD_MOVE))
    else $error("two words at once");
  chk_move_busy: assert property ((O_WORD_MOVE & ~$past(O_CHAN_BUSY)) == 6'h00)
    else $error("word from idle channel");
endmodule // dma_channel_control_checker

bind dma_channel_control dma_channel_control_checker chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
  .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_WORD_MOVE(O_WORD_MOVE),
  .O_CHAN_BUSY(O_CHAN_BUSY), .O_IRQ(O_IRQ));

// file: tb/dma_channel_control_tb.sv
// Self-checking bench for the DMA channel control block
`timescale 1ns/1ps
`include "dma_channel_control_consts.vh"
module dma_channel_control_tb;
  logic I_CLK = 0, I_RST_N = 0, I_PSEL = 0, I_PENABLE = 0, I_PWRITE = 0, O_PREADY, O_PSLVERR;
  logic O_IRQ, er;
  logic [7:0] I_PADDR = 8'h00;
  logic [31:0] I_PWDATA = 32'h0, O_PRDATA, rd;
  logic [5:0] I_DMA_REQ, O_WORD_MOVE, O_CHAN_BUSY, want = 6'h00;
  int miscompares = 0, samples_checked = 0, moves = 0;
  dma_channel_control dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_DMA_REQ(I_DMA_REQ),
    .O_WORD_MOVE(O_WORD_MOVE), .O_CHAN_BUSY(O_CHAN_BUSY), .O_IRQ(O_IRQ));
  dma_req_model req (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_want(want), .o_req(I_DMA_REQ));
  initial forever #5 I_CLK = ~I_CLK;
  // Words moved so far, all channels
  always @(posedge I_CLK) if (|O_WORD_MOVE) moves <= moves + 1;
  task tick(input int n);
    repeat (n) @(posedge I_CLK);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      samples_checked++;
      if (g !== e) begin
        miscompares++;
        $display("BAD %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  // One APB transfer; the slave decides how long the access lasts
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    begin
      I_PSEL <= 1'b1;
      I_PWRITE <= w;
      I_PADDR <= a;
      I_PWDATA <= d;
      @(posedge I_CLK);
      I_PENABLE <= 1'b1;
      // Only the watchdog ends a wait that never sees ready
      do begin
        @(posedge I_CLK);
      end while (O_PREADY !== 1'b1);
      rd = O_PRDATA;
      er = O_PSLVERR;
      I_PSEL <= 1'b0;
      I_PENABLE <= 1'b0;
      @(posedge I_CLK);
    end
  endtask
  task regs_reset;
    begin
      for (int c = 0; c < 6; c++) begin
        apb(0, 8'(4 * c), 0);
        chk("ctl reset", 0, rd);
      end
      apb(1, 8'h14, 32'hFF07FFFF);
      apb(0, 8'h14, 0);
      chk("ctl rw", 32'h0007FFFF, rd);
      chk("mapped err", 0, er);
      apb(1, 8'h34, 32'hFFFF1234);
      apb(0, 8'h34, 0);
      chk("preset rw", 32'h00001234, rd);
      apb(1, 8'h14, 0);
      apb(0, 8'h18, 0);
      chk("unmapped err", 1, er);
      chk("unmapped data", 0, rd);
      apb(1, `ADDR_MASK, 32'h3F3F);
      apb(0, `ADDR_MASK, 0);
      chk("mask rw", 32'h00003F3F, rd);
    end
  endtask
  // Every mode once, reserved code and interrupt disabled last
  task mode_table;
    logic [23:0] ctl [8] = '{24'hC00000, 24'hC80000, 24'hD00000, 24'hD80000,
      24'hE00000, 24'hE80000, 24'h980000, 24'hB00000};
    logic [23:0] fin [8] = '{24'h400000, 24'h480000, 24'h500000, 24'h580000,
      24'hE00000, 24'hE80000, 24'h180000, 24'hB00000};
    int pre [8] = '{1, 1, 7, 2, 1, 3, 0, 0};
    int nrq [8] = '{1, 2, 2, 0, 2, 2, 0, 1};
    int nw [8] = '{2, 2, 8, 3, 4, 2, 1, 0};
    int base, ch;
    begin
      for (int i = 0; i < 8; i++) begin
        ch = i % 6;
        base = moves;
        apb(1, 8'h20 + 8'(4 * ch), pre[i]);
        apb(1, 8'(4 * ch), ctl[i]);
        tick(4);
        if (nrq[i] > 0) chk("armed only", 0, moves - base);
        apb(0, `ADDR_BUSY, 0);
        chk("armed busy", (nrq[i] > 0 && i < 6) ? 32'h1 << ch : 32'h0, rd);
        chk("busy pin", (nrq[i] > 0 && i < 6) ? 32'h1 << ch : 32'h0, O_CHAN_BUSY);
        for (int r = 0; r < nrq[i]; r++) begin
          want <= 6'h01 << ch;
          tick(1);
          want <= 6'h00;
          tick(12);
        end
        tick(20);
        chk("words", nw[i], moves - base);
        apb(0, 8'(4 * ch), 0);
        chk("ctl end", fin[i], rd);
        apb(0, `ADDR_STATUS, 0);
        chk("status", (i < 4) ? 32'h1 << ch : 32'h0, rd);
        chk("irq", rd != 0, O_IRQ);
        apb(1, 8'(4 * ch), 0);
        chk("irq kept", rd != 0, O_IRQ);
        apb(0, `ADDR_STATUS, 0);
        chk("status held", (i < 4) ? 32'h1 << ch : 32'h0, rd);
        apb(1, `ADDR_STATUS, rd);
        tick(2);
        chk("irq clear", 0, O_IRQ);
        chk("busy", 0, O_CHAN_BUSY);
      end
    end
  endtask
  // Go cleared by software in mid-block on channel 2
  task stop_in_flight;
    int m;
    begin
      apb(1, 8'h28, 32'hFF);
      apb(1, 8'h08, 32'hD80000);
      tick(6);
      apb(1, 8'h08, 32'h580000);
      tick(1);
      chk("in flight", 32'h4, O_WORD_MOVE);
      tick(1);
      chk("stopped", 0, O_WORD_MOVE);
      m = moves;
      tick(10);
      chk("frozen", m, moves);
      chk("stop busy", 0, O_CHAN_BUSY);
      apb(0, `ADDR_STATUS, 0);
      chk("stop status", 32'h400, rd);
      apb(1, `ADDR_MASK, 0);
      tick(2);
      chk("irq masked", 0, O_IRQ);
      apb(1, `ADDR_MASK, 32'h3F3F);
      tick(2);
      chk("irq held", 1, O_IRQ);
      apb(1, `ADDR_STATUS, 32'h400);
      tick(2);
      chk("irq cleared", 0, O_IRQ);
    end
  endtask
  // Reset in mid-run clears every control bit and stops a running channel
  task reset_mid_run;
    begin
      apb(1, 8'h00, 32'h0007FFFF);
      apb(1, 8'h2C, 32'hFF);
      apb(1, 8'h0C, 32'hD80000);
      tick(2);
      chk("run before reset", 32'h8, O_CHAN_BUSY);
      I_RST_N <= 1'b0;
      tick(2);
      I_RST_N <= 1'b1;
      tick(3);
      chk("busy after reset", 0, O_CHAN_BUSY);
      apb(0, 8'h00, 0);
      chk("ctl0 after reset", 0, rd);
      apb(0, 8'h0C, 0);
      chk("ctl3 after reset", 0, rd);
    end
  endtask
  task print_verdict;
    begin
      $display("Comparisons %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
        $display("No errors found");
      end else begin
        $display("Errors were found");
      end
      $finish;
    end
  endtask
  // Cuts a hang short
  initial begin
    tick(50000);
    miscompares++;
    print_verdict;
  end
  // Main sequence
  initial begin
    tick(2);
    I_RST_N <= 1'b1;
    tick(3);
    regs_reset;
    mode_table;
    stop_in_flight;
    reset_mid_run;
    print_verdict;
  end
endmodule // dma_channel_control_tb

// file: tb/dma_req_model.sv
// Requesting peripherals: one-cycle request pulses on command
`timescale 1ns/1ps
module dma_req_model (
  // Clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // Command in, requests out
  input wire [5:0] i_want,
  output reg [5:0] o_req
);
  // Pulses only, so a word mode never takes one command twice
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) o_req <= 6'h00;
    else o_req <= i_want;
  end
endmodule // dma_req_model

// file: verilog/dma_channel_control.v
// Six-channel DMA control registers, sequencing, arbitration and interrupt
//
// Overview of operation
// - Six read/write control registers, all bits cleared by reset.
// - Go bit starts a block in go mode, only arms request modes.
// - Clearing go mid-transfer stops after the word in flight completes.
// - With irq enable, end of block in modes 000 to 011 raises interrupt after counter reload.
// - With irq enable, software clearing go mid-transfer raises interrupt.
// - Pending interrupt held until the service clears it.
// - Irq enable clear means no new interrupt cause from that channel.
// - Mode field at bits 21..19 picks trigger, granularity, go auto-clear.
// - Mode 000: request-started whole block, go cleared at end.
// - Mode 001: one word per request, go cleared at block end.
// - Mode 010: one line per request, go cleared at block end.
// - Mode 011: go alone starts whole block, go cleared at end.
// - Block complete when counter reaches zero and is reloaded.
// - Mode 100: block per first request, go kept, waits next request.
// - Mode 101: word per request, counter reloads at zero, go kept.
// - Rank field at bits 18..17 orders channels; 00 lowest.
`timescale 1ns/1ps
`include "dma_channel_control_consts.vh"

module dma_channel_control (
  // Clock and reset
  input wire I_CLK,
  input wire I_RST_N,
  // APB slave
  input wire I_PSEL,
  input wire I_PENABLE,
  input wire I_PWRITE,
  input wire [7:0] I_PADDR,
  input wire [31:0] I_PWDATA,
  output wire [31:0] O_PRDATA,
  output wire O_PREADY,
  output wire O_PSLVERR,
  // Requesting peripherals
  input wire [5:0] I_DMA_REQ,
  // Transfer side
  output wire [5:0] O_WORD_MOVE,
  output wire [5:0] O_CHAN_BUSY,
  // Interrupt
  output wire O_IRQ
);

  // Mode needs go bit cleared at block end
  function mode_auto_clear;
    input [2:0] m;
    begin
      mode_auto_clear = (m[2] == 1'b0);
    end
  endfunction

  // Mode code is one of the six defined ones
  function mode_valid;
    input [2:0] m;
    begin
      mode_valid = (m[2:1] != 2'h3);
    end
  endfunction

  // Mode starts a block on the go bit alone
  function mode_go_start;
    input [2:0] m;
    begin
      mode_go_start = (m == `MODE_BLK_GO);
    end
  endfunction

  // Mode moves one word per request
  function mode_per_word;
    input [2:0] m;
    begin
      mode_per_word = (m == `MODE_WORD_REQ) || (m == `MODE_WORD_REPEAT);
    end
  endfunction

  // Rank field of one control word
  function [1:0] ch_rank;
    input [`CTL_W-1:0] w;
    begin
      ch_rank = w[`RANK_HI:`RANK_LO];
    end
  endfunction

  // Two cause vectors placed in the status layout; other bits read zero
  function [31:0] pack_causes;
    input [5:0] eob;
    input [5:0] stop;
    begin
      pack_causes = 32'h00000000;
      pack_causes[`STAT_EOB_HI:`STAT_EOB_LO] = eob;
      pack_causes[`STAT_STOP_HI:`STAT_STOP_LO] = stop;
    end
  endfunction

  // Reset synchroniser
  reg rst_meta_q;
  reg rst_n_q;

  // Release through two flops; only the second is used
  // Assertion acts at once; only the release waits two edges
  always @(posedge I_CLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      rst_meta_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q <= rst_meta_q;
    end
  end

  // Per-channel state
  reg [`CTL_W-1:0] ctl_q [0:`NUM_CH-1];
  reg [`CTL_W-1:0] ctl_d [0:`NUM_CH-1];
  reg [`CNT_W-1:0] preset_q [0:`NUM_CH-1];
  reg [`CNT_W-1:0] preset_d [0:`NUM_CH-1];
  reg [`CNT_W-1:0] cur_q [0:`NUM_CH-1];
  reg [`CNT_W-1:0] cur_d [0:`NUM_CH-1];
  reg [1:0] phase_q [0:`NUM_CH-1];
  reg [1:0] phase_d [0:`NUM_CH-1];
  reg [`LINE_W-1:0] line_q [0:`NUM_CH-1];
  reg [`LINE_W-1:0] line_d [0:`NUM_CH-1];

  // Interrupt state
  reg [5:0] eob_q;
  reg [5:0] stop_q;
  reg [5:0] eob_mask_q;
  reg [5:0] stop_mask_q;
  reg [5:0] eob_set;
  reg [5:0] stop_set;
  reg irq_q;

  // Bus and output flops, with the combinational read data and hit
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;
  reg [31:0] rd_data;
  reg rd_hit;
  reg [5:0] move_q;
  reg [5:0] busy_q;

  // Arbitration
  reg [5:0] grant;
  reg [1:0] best_rank;
  reg found;
  integer a;

  // APB decode
  wire access = I_PSEL & I_PENABLE;
  wire wr_en = access & I_PWRITE & pready_q;
  wire [2:0] region = I_PADDR[`REGION_HI:`REGION_LO];
  wire [2:0] idx = I_PADDR[`IDX_HI:`IDX_LO];
  wire idx_ok = (idx < `NUM_CH);

  // Register hits, shared by the write strobes and the read mux
  wire ctl_hit = (region == `REGION_CTL) & idx_ok;
  wire preset_hit = (region == `REGION_PRESET) & idx_ok;
  wire status_hit = (I_PADDR == `ADDR_STATUS);
  wire mask_hit = (I_PADDR == `ADDR_MASK);
  wire busy_hit = (I_PADDR == `ADDR_BUSY);

  // Writes land only at the edge that ends the access
  wire wr_ctl = wr_en & ctl_hit;
  wire wr_preset = wr_en & preset_hit;
  wire wr_status = wr_en & status_hit;
  wire wr_mask = wr_en & mask_hit;

  // Write-one-to-clear masks, zero unless software writes the status word
  wire [5:0] eob_clr = wr_status ? I_PWDATA[`STAT_EOB_HI:`STAT_EOB_LO] : 6'h00;
  wire [5:0] stop_clr = wr_status ? I_PWDATA[`STAT_STOP_HI:`STAT_STOP_LO] : 6'h00;
  // Pending causes that software lets through
  wire [5:0] eob_live = eob_q & eob_mask_q;
  wire [5:0] stop_live = stop_q & stop_mask_q;

  // One word slot per cycle, highest rank wins, lower index breaks ties
  always @* begin
    grant = 6'h00;
    best_rank = 2'h0;
    found = 1'b0;
    for (a = 0; a < `NUM_CH; a = a + 1) begin
      if (phase_q[a] == `PH_RUN &&
          (!found || ch_rank(ctl_q[a]) > best_rank)) begin
        grant = 6'h00;
        grant[a] = 1'b1;
        best_rank = ch_rank(ctl_q[a]);
        found = 1'b1;
      end
    end
  end

  // Channel sequencing and register writes
  integer c;
  reg [2:0] mode;
  reg go;
  reg ien;
  always @* begin
    mode = 3'h0;
    go = 1'b0;
    ien = 1'b0;
    eob_set = 6'h00;
    stop_set = 6'h00;
    for (c = 0; c < `NUM_CH; c = c + 1) begin
      ctl_d[c] = ctl_q[c];
      preset_d[c] = preset_q[c];
      cur_d[c] = cur_q[c];
      phase_d[c] = phase_q[c];
      line_d[c] = line_q[c];
      mode = ctl_q[c][`MODE_HI:`MODE_LO];
      go = ctl_q[c][`GO_BIT];
      ien = ctl_q[c][`IRQ_EN_BIT];
      case (phase_q[c])
        `PH_IDLE: begin
          // Reserved modes never leave idle
          if (go && mode_valid(mode)) begin
            if (mode_go_start(mode)) begin
              phase_d[c] = `PH_RUN;
            end else begin
              phase_d[c] = `PH_WAIT;
            end
          end
        end
        `PH_WAIT: begin
          // Go cleared while armed: idle quietly, no stop cause
          if (!go) begin
            phase_d[c] = `PH_IDLE;
          end else if (I_DMA_REQ[c]) begin
            phase_d[c] = `PH_RUN;
            line_d[c] = `LINE_LAST;
          end
        end
        `PH_RUN: begin
          if (grant[c]) begin
            // Line position runs in every mode but is read in line mode only
            line_d[c] = line_q[c] - 3'h1;
            if (cur_q[c] == {`CNT_W{1'b0}}) begin
              // Block end: reload, then clear go or wait again
              cur_d[c] = preset_q[c];
              if (mode_auto_clear(mode)) begin
                ctl_d[c][`GO_BIT] = 1'b0;
                phase_d[c] = `PH_IDLE;
                eob_set[c] = ien;
              end else begin
                phase_d[c] = `PH_WAIT;
              end
            end else begin
              cur_d[c] = cur_q[c] - 16'h0001;
              if (mode_per_word(mode)) begin
                phase_d[c] = `PH_WAIT;
              end else if (mode == `MODE_LINE_REQ && line_q[c] == 3'h0) begin
                phase_d[c] = `PH_WAIT;
              end
            end
          end
          // Software stop: a granted word still completes this cycle
          if (!go) begin
            phase_d[c] = `PH_IDLE;
            stop_set[c] = ien;
          end
        end
        default: begin
          phase_d[c] = `PH_IDLE;
        end
      endcase
      // A software write overrides hardware go clearing
      if (wr_ctl && idx == c[2:0]) begin
        ctl_d[c] = I_PWDATA[`CTL_W-1:0];
      end
      if (wr_preset && idx == c[2:0]) begin
        preset_d[c] = I_PWDATA[`CNT_W-1:0];
        cur_d[c] = I_PWDATA[`CNT_W-1:0];
      end
    end
  end

  // Channel registers
  // One reset for all fields so no channel wakes half-cleared
  integer r;
  always @(posedge I_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      for (r = 0; r < `NUM_CH; r = r + 1) begin
        ctl_q[r] <= `CTL_RESET;
        preset_q[r] <= {`CNT_W{1'b0}};
        cur_q[r] <= {`CNT_W{1'b0}};
        phase_q[r] <= `PH_IDLE;
        line_q[r] <= {`LINE_W{1'b0}};
      end
    end else begin
      for (r = 0; r < `NUM_CH; r = r + 1) begin
        ctl_q[r] <= ctl_d[r];
        preset_q[r] <= preset_d[r];
        cur_q[r] <= cur_d[r];
        phase_q[r] <= phase_d[r];
        line_q[r] <= line_d[r];
      end
    end
  end

  // Sticky causes; a new event beats a same-cycle clear
  always @(posedge I_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      eob_q <= 6'h00;
      stop_q <= 6'h00;
      eob_mask_q <= 6'h00;
      stop_mask_q <= 6'h00;
      irq_q <= 1'b0;
    end else begin
      eob_q <= (eob_q & ~eob_clr) | eob_set;
      stop_q <= (stop_q & ~stop_clr) | stop_set;
      if (wr_mask) begin
        eob_mask_q <= I_PWDATA[`STAT_EOB_HI:`STAT_EOB_LO];
        stop_mask_q <= I_PWDATA[`STAT_STOP_HI:`STAT_STOP_LO];
      end
      // Masking hides a cause from the pin but leaves it pending
      irq_q <= |(eob_live | stop_live);
    end
  end

  // Read mux; unmapped addresses flag an error
  always @* begin
    rd_data = 32'h00000000;
    rd_hit = 1'b1;
    if (ctl_hit) begin
      rd_data[`CTL_W-1:0] = ctl_q[idx];
    end else if (preset_hit) begin
      rd_data[`CNT_W-1:0] = preset_q[idx];
    end else if (status_hit) begin
      rd_data = pack_causes(eob_q, stop_q);
    end else if (mask_hit) begin
      rd_data = pack_causes(eob_mask_q, stop_mask_q);
    end else if (busy_hit) begin
      rd_data[`BUSY_HI:`BUSY_LO] = busy_q;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One wait state so read data comes from a flop
  always @(posedge I_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= access & ~pready_q;
      pslverr_q <= access & ~pready_q & ~rd_hit;
      if (access && !pready_q && !I_PWRITE) begin
        prdata_q <= rd_data;
      end
    end
  end

  // Transfer side outputs
  // Busy follows the next phase so it rises with the channel leaving idle
  integer b;
  always @(posedge I_CLK or negedge rst_n_q) begin
    if (!rst_n_q) begin
      move_q <= 6'h00;
      busy_q <= 6'h00;
    end else begin
      move_q <= grant;
      for (b = 0; b < `NUM_CH; b = b + 1) begin
        busy_q[b] <= (phase_d[b] != `PH_IDLE);
      end
    end
  end

  assign O_PRDATA = prdata_q;
  assign O_PREADY = pready_q;
  assign O_PSLVERR = pslverr_q;
  assign O_WORD_MOVE = move_q;
  assign O_CHAN_BUSY = busy_q;
  assign O_IRQ = irq_q;

endmodule // dma_channel_control
